// ---- core/dram_ctrl_defs.vh ----
// Constants for the page-mode DRAM controller.
// Assumes a 10 MHz processor clock, which is the only clock of the block.
`ifndef DRAM_CTRL_DEFS_VH
`define DRAM_CTRL_DEFS_VH

// Transfer size codes on xfer_size
`define SIZE_LONG 2'h0
`define SIZE_BYTE 2'h1
`define SIZE_WORD 2'h2

// Address map: 24-bit bus, two 2 MB banks in the low 4 MB
`define REGION_HI_MSB 23
`define REGION_HI_LSB 22
`define REGION_HI_VAL 2'h0
`define BANK_BIT 21
// Least significant address bit picks the byte lane of a byte transfer
`define BYTE_LSB 0
// Page is 2 KB: address bits 20..11 are the row, 10..1 the column
`define ROW_MSB 20
`define ROW_LSB 11
`define COL_MSB 10
`define COL_LSB 1
`define ROW_W 10

// Acknowledge codes: 16-bit port, idle
`define ACK_PORT16 2'h1
`define ACK_IDLE 2'h3

`endif

// ---- core/page_detect.v ----
// Page detector: latches the row and bank of the access that opened the
// page and flags whether the present address hits that open page.
// Assumes the address is already synchronised to the processor clock.
`timescale 1ns/1ps
`include "dram_ctrl_defs.vh"

module page_detect #(
   parameter ROW_W = `ROW_W
) (
   input wire i_clk_sys,
   input wire i_resetn,
   input wire i_load,
   input wire i_close,
   input wire [ROW_W-1:0] i_row,
   input wire i_bank,
   output wire o_page_hit
);

   reg [ROW_W-1:0] row_q;
   reg bank_q;
   reg open_q;

   // ***************************************************
   // Stored page
   // ***************************************************
   // latch page address
   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         row_q <= {ROW_W{1'b0}};
         bank_q <= 1'b0;
         open_q <= 1'b0;
      end else if (i_load) begin
         row_q <= i_row;
         bank_q <= i_bank;
         open_q <= 1'b1;
      end else if (i_close) begin
         open_q <= 1'b0;
      end
   end

   assign o_page_hit = open_q && (row_q == i_row) && (bank_q == i_bank);

endmodule

// ---- core/page_mode_dram_controller.v ----
// Page-mode DRAM controller for a 16-bit two-bank fast-page-mode array
// behind a processor bus with address strobe and size acknowledge.
// Assumes bus inputs change on the processor clock but are treated as
// asynchronous; they pass two flip-flops before any logic reads them.
//
// Contract
// - Page hit finishes in 3 clocks, first access in 4, page miss in 6.
// - Row stays open across same-page accesses, no precharge between them.
// - Upper acknowledge line only (16-bit port code) is driven low during every DRAM access to signal data.
// - Active-low reset returns state machine and all registers to start.
// - Multiplexed address shows row first, then column, on a first access or page miss; a page hit shows only the column.
// - Active-low write enable asserted for writes, early-write timing.
// - Two row strobes, one per bank, only addressed bank asserted.
// - Two column strobes, upper lane bits 15..8, lower lane bits 7..0.
// - Byte at even address asserts only upper column strobe.
// - Byte at odd address asserts only lower column strobe.
// - Word and long-word transfers assert both column strobes.
// - Mode decode: size 01 byte, 10 word, 00 aligned long word.
// - Latch address per strobe; same page flags hit, short cycle.
`timescale 1ns/1ps
`include "dram_ctrl_defs.vh"

module page_mode_dram_controller #(
   parameter ADDR_W = 24,
   parameter MA_W = `ROW_W
) (
   input wire i_clk_sys,
   input wire i_resetn,
   input wire [ADDR_W-1:0] i_addr,
   input wire i_addr_strobe_n,
   input wire i_read_write_n,
   input wire [1:0] i_xfer_size,
   output reg [1:0] o_data_size_ack_n,
   output reg [MA_W-1:0] o_dram_mux_addr,
   output reg o_dram_write_en_n,
   output reg o_row_strobe_bank1_n,
   output reg o_row_strobe_bank2_n,
   output reg o_col_strobe_hi_n,
   output reg o_col_strobe_lo_n
);

   // ***************************************************
   // States (one-hot)
   // ***************************************************
   // One-hot codes keep every state decode a single bit test
   localparam [7:0] ST_IDLE = 8'h01;
   localparam [7:0] ST_RW1 = 8'h02; // Row strobe, row address out
   localparam [7:0] ST_RW2 = 8'h04; // Column strobe
   localparam [7:0] ST_RW3 = 8'h08; // Data taken, column strobe still low
   localparam [7:0] ST_PG1 = 8'h10; // Page hit: column strobe
   localparam [7:0] ST_PG2 = 8'h20; // Data taken
   localparam [7:0] ST_PG3 = 8'h40; // Column precharge, row held open
   localparam [7:0] ST_PRE = 8'h80; // Row precharge on page miss

   // ***************************************************
   // Input synchronisers
   // ***************************************************
   reg [ADDR_W-1:0] addr_s1_q, addr_s2_q;
   reg as_s1_q, as_s2_q;
   reg rw_s1_q, rw_s2_q;
   reg [1:0] size_s1_q, size_s2_q;

   // Two stages on every bus input before any logic reads it.
   // Trade-off: two clocks of latency on each access, but bus inputs
   // may then change at any point of the clock without risk.
   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         addr_s1_q <= {ADDR_W{1'b0}};
         addr_s2_q <= {ADDR_W{1'b0}};
         as_s1_q <= 1'b1;
         as_s2_q <= 1'b1;
         rw_s1_q <= 1'b1;
         rw_s2_q <= 1'b1;
         size_s1_q <= 2'h0;
         size_s2_q <= 2'h0;
      end else begin
         addr_s1_q <= i_addr;
         addr_s2_q <= addr_s1_q;
         as_s1_q <= i_addr_strobe_n;
         as_s2_q <= as_s1_q;
         rw_s1_q <= i_read_write_n;
         rw_s2_q <= rw_s1_q;
         size_s1_q <= i_xfer_size;
         size_s2_q <= size_s1_q;
      end
   end

   // ***************************************************
   // Decode
   // ***************************************************
   wire region_hit;
   wire bank_sel;
   wire [MA_W-1:0] row_addr;
   wire [MA_W-1:0] col_addr;
   wire lane_hi;
   wire lane_lo;
   wire page_hit;
   wire is_byte;
   reg load_page;
   reg close_page;

   // Region select qualified by the address strobe, as the cycle start
   assign region_hit = !as_s2_q &&
      (addr_s2_q[`REGION_HI_MSB:`REGION_HI_LSB] == `REGION_HI_VAL);
   assign bank_sel = addr_s2_q[`BANK_BIT];
   assign row_addr = addr_s2_q[`ROW_MSB:`ROW_LSB];
   assign col_addr = addr_s2_q[`COL_MSB:`COL_LSB];

   assign is_byte = (size_s2_q == `SIZE_BYTE);
   // Long words come as two 16-bit accesses, so every size other than
   // a byte simply opens both lanes
   // even byte upper lane
   assign lane_hi = !is_byte || !addr_s2_q[`BYTE_LSB];
   assign lane_lo = !is_byte || addr_s2_q[`BYTE_LSB];

   page_detect #(
      .ROW_W(MA_W)
   ) u_page_detect (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_load(load_page),
      .i_close(close_page),
      .i_row(row_addr),
      .i_bank(bank_sel),
      .o_page_hit(page_hit)
   );

   // ***************************************************
   // State machine
   // ***************************************************
   reg [7:0] state_q, state_d;
   reg bank_q, bank_d;
   reg done_q, done_d;

   // Waits for strobe release after each access so one bus cycle
   // is never served twice.
   // Limitation: no refresh here; the row stays open until a page
   // miss, so the system must bound the time between accesses.
   always @* begin
      state_d = state_q;
      bank_d = bank_q;
      done_d = done_q;
      load_page = 1'b0;
      close_page = 1'b0;
      // Strobe release re-arms the machine for the next bus cycle
      if (as_s2_q) begin
         done_d = 1'b0;
      end
      case (state_q)
         ST_IDLE: begin
            if (region_hit && !done_q) begin
               state_d = ST_RW1;
               bank_d = bank_sel;
               load_page = 1'b1;
            end
         end
         ST_RW1: begin
            state_d = ST_RW2;
         end
         ST_RW2: begin
            state_d = ST_RW3;
            done_d = 1'b1;
         end
         ST_RW3: begin
            state_d = ST_PG3;
         end
         ST_PG3: begin
            if (region_hit && !done_q && page_hit) begin
               state_d = ST_PG1;
            end else if (region_hit && !done_q) begin
               // Close the stored page now so no stale hit can follow
               state_d = ST_PRE;
               close_page = 1'b1;
            end
         end
         ST_PG1: begin
            state_d = ST_PG2;
            done_d = 1'b1;
         end
         ST_PG2: begin
            state_d = ST_PG3;
         end
         ST_PRE: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
            close_page = 1'b1;
         end
      endcase
   end

   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q <= ST_IDLE;
         bank_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         bank_q <= bank_d;
         done_q <= done_d;
      end
   end

   // ***************************************************
   // DRAM and acknowledge outputs
   // ***************************************************
   reg row_on;
   reg col_on;
   reg ack_on;
   reg show_col;

   // Strobe activity per next state; outputs are registered
   always @* begin
      row_on = 1'b0;
      col_on = 1'b0;
      ack_on = 1'b0;
      show_col = 1'b0;
      case (state_d)
         ST_RW1: begin
            row_on = 1'b1;
            ack_on = 1'b1;
         end
         ST_RW2, ST_PG1: begin
            row_on = 1'b1;
            col_on = 1'b1;
            ack_on = 1'b1;
            show_col = 1'b1;
         end
         ST_RW3, ST_PG2: begin
            row_on = 1'b1;
            col_on = 1'b1;
            show_col = 1'b1;
         end
         ST_PG3: begin
            row_on = 1'b1;
            show_col = 1'b1;
         end
         default: begin
            row_on = 1'b0;
         end
      endcase
   end

   // Acknowledge, one flip-flop so the processor sees a clean level
   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_data_size_ack_n <= `ACK_IDLE;
      end else begin
         o_data_size_ack_n <= ack_on ? `ACK_PORT16 : `ACK_IDLE;
      end
   end

   // Multiplexed address; it stays on the column while the row is held
   // open so the lines do not toggle between page-mode accesses
   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_dram_mux_addr <= {MA_W{1'b0}};
      end else begin
         o_dram_mux_addr <= show_col ? col_addr : row_addr;
      end
   end

   // Strobes and write enable; write enable follows the open row so it
   // is already low when the column strobe falls, as early write needs
   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_dram_write_en_n <= 1'b1;
         o_row_strobe_bank1_n <= 1'b1;
         o_row_strobe_bank2_n <= 1'b1;
         o_col_strobe_hi_n <= 1'b1;
         o_col_strobe_lo_n <= 1'b1;
      end else begin
         o_dram_write_en_n <= !(row_on && !rw_s2_q);
         o_row_strobe_bank1_n <= !(row_on && !bank_d);
         o_row_strobe_bank2_n <= !(row_on && bank_d);
         o_col_strobe_hi_n <= !(col_on && lane_hi);
         o_col_strobe_lo_n <= !(col_on && lane_lo);
      end
   end

endmodule

// ---- sim/dram_ctrl_properties.sv ----
// Port checker for the page-mode DRAM controller.
// Assumes bus inputs reach the logic two clocks late (two-stage sync).
`timescale 1ns/1ps
module dram_ctrl_properties #(
   parameter ADDR_W = 24,
   parameter MA_W = 10
) (
   input wire i_clk_sys,
   input wire i_resetn,
   input wire [ADDR_W-1:0] i_addr,
   input wire i_addr_strobe_n,
   input wire i_read_write_n,
   input wire [1:0] i_xfer_size,
   input wire [1:0] o_data_size_ack_n,
   input wire [MA_W-1:0] o_dram_mux_addr,
   input wire o_dram_write_en_n,
   input wire o_row_strobe_bank1_n,
   input wire o_row_strobe_bank2_n,
   input wire o_col_strobe_hi_n,
   input wire o_col_strobe_lo_n
);
   // ****
   // Helpers
   // ****
   // Combined strobes; $past depth 2 matches the input synchroniser
   wire row_n = o_row_strobe_bank1_n & o_row_strobe_bank2_n;
   wire col_n = o_col_strobe_hi_n & o_col_strobe_lo_n;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);

   a_ack_lo_high: assert property (o_data_size_ack_n[0])
      else $error("lower acknowledge line low");
   a_one_bank: assert property (o_row_strobe_bank1_n
      | o_row_strobe_bank2_n)
      else $error("both row strobes low");
   a_ack_in_row: assert property (!o_data_size_ack_n[1] |-> !row_n)
      else $error("acknowledge outside an access");
   a_ack_bound: assert property ($fell(o_data_size_ack_n[1])
      |-> ##[1:2] o_data_size_ack_n[1])
      else $error("acknowledge held too long");
   a_col_in_row: assert property (!col_n |-> !row_n)
      else $error("column strobe without open row");
   a_we_in_row: assert property (!o_dram_write_en_n |-> !row_n)
      else $error("write enable without open row");
   a_row_addr: assert property ($fell(row_n)
      |-> o_dram_mux_addr == $past(i_addr[20:11], 2))
      else $error("row address wrong at row strobe");
   a_col_addr: assert property ($fell(col_n)
      |-> o_dram_mux_addr == $past(i_addr[10:1], 2))
      else $error("column address wrong at column strobe");
   a_lane_hi: assert property ($fell(col_n)
      |-> o_col_strobe_hi_n ==
      ($past(i_xfer_size, 2) == 2'h1 && $past(i_addr[0], 2)))
      else $error("upper lane strobe wrong");
   a_lane_lo: assert property ($fell(col_n)
      |-> o_col_strobe_lo_n ==
      ($past(i_xfer_size, 2) == 2'h1 && !$past(i_addr[0], 2)))
      else $error("lower lane strobe wrong");
   a_we_early: assert property ($fell(col_n)
      |-> o_dram_write_en_n == $past(i_read_write_n, 2))
      else $error("write enable wrong at column strobe");
   a_bank_sel: assert property ($fell(row_n)
      |-> o_row_strobe_bank2_n == !$past(i_addr[21], 2))
      else $error("wrong bank row strobe");
endmodule

bind page_mode_dram_controller dram_ctrl_properties #(
   .ADDR_W(ADDR_W), .MA_W(MA_W)
) props (.i_clk_sys, .i_resetn, .i_addr, .i_addr_strobe_n, .i_read_write_n,
   .i_xfer_size, .o_data_size_ack_n, .o_dram_mux_addr, .o_dram_write_en_n,
   .o_row_strobe_bank1_n, .o_row_strobe_bank2_n, .o_col_strobe_hi_n,
   .o_col_strobe_lo_n);

// ---- sim/dram_bank_model.sv ----
// Observer model of the two 16-bit DRAM banks behind the controller.
// Assumes strobes are registered on the rising edge of the clock.
`timescale 1ns/1ps
module dram_bank_model (
   input wire i_clk_sys,
   input wire [9:0] i_mux_addr,
   input wire i_we_n,
   input wire i_row1_n,
   input wire i_row2_n,
   input wire i_hi_n,
   input wire i_lo_n,
   output logic [9:0] o_row,
   output logic [9:0] o_col,
   output logic o_bank2,
   output logic o_we_n,
   output logic [1:0] o_lanes,
   output int o_col_cnt
);
   logic row_q = 1'b1;
   logic col_q = 1'b1;
   initial o_col_cnt = 0;
   // Latch on strobe fall; falling clock edge avoids racing the outputs
   always @(negedge i_clk_sys) begin
      if (!(i_row1_n & i_row2_n) && row_q) begin
         o_row <= i_mux_addr;
         o_bank2 <= !i_row2_n;
      end
      if (!(i_hi_n & i_lo_n) && col_q) begin
         o_col <= i_mux_addr;
         o_lanes <= {!i_hi_n, !i_lo_n};
         o_we_n <= i_we_n;
         o_col_cnt <= o_col_cnt + 1;
      end
      row_q <= i_row1_n & i_row2_n;
      col_q <= i_hi_n & i_lo_n;
   end
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the page-mode DRAM controller.
// Assumes the bank model and the bound port checker are compiled first.
`timescale 1ns/1ps
`include "dram_ctrl_defs.vh"
module testbench;
   logic i_clk_sys = 1'b0;
   logic i_resetn = 1'b0;
   logic [23:0] i_addr = 24'h00_0000;
   logic i_addr_strobe_n = 1'b1;
   logic i_read_write_n = 1'b1;
   logic [1:0] i_xfer_size = `SIZE_WORD;
   wire [1:0] o_data_size_ack_n;
   wire [9:0] o_dram_mux_addr, m_row, m_col;
   wire o_dram_write_en_n, o_row_strobe_bank1_n, o_row_strobe_bank2_n;
   wire o_col_strobe_hi_n, o_col_strobe_lo_n, m_bank2, m_we_n;
   wire [1:0] m_lanes;
   wire [6:0] ctl = {o_data_size_ack_n, o_dram_write_en_n,
      o_row_strobe_bank1_n, o_row_strobe_bank2_n, o_col_strobe_hi_n,
      o_col_strobe_lo_n};
   int m_cnt;
   int bad_count = 0;
   int tests_run = 0;
   int cycles = 0;
   typedef struct {logic [23:0] a; logic rw; logic [1:0] sz;
      int acks; logic [1:0] lanes;} row_t;
   // Same-page runs, long-word pair, bank change and page misses
   row_t rows [8] = '{'{24'h00_0000, 1, `SIZE_BYTE, 2, 2'h2},
      '{24'h00_0001, 1, `SIZE_BYTE, 1, 2'h1},
      '{24'h00_0002, 0, `SIZE_WORD, 1, 2'h3},
      '{24'h00_0004, 0, `SIZE_LONG, 1, 2'h3},
      '{24'h00_0006, 0, `SIZE_WORD, 1, 2'h3},
      '{24'h20_0800, 1, `SIZE_WORD, 2, 2'h3},
      '{24'h20_0803, 0, `SIZE_BYTE, 1, 2'h1},
      '{24'h00_0800, 1, `SIZE_WORD, 2, 2'h3}};

   page_mode_dram_controller dut (.i_clk_sys, .i_resetn, .i_addr,
      .i_addr_strobe_n, .i_read_write_n, .i_xfer_size, .o_data_size_ack_n,
      .o_dram_mux_addr, .o_dram_write_en_n, .o_row_strobe_bank1_n,
      .o_row_strobe_bank2_n, .o_col_strobe_hi_n, .o_col_strobe_lo_n);
   dram_bank_model far (.i_clk_sys, .i_mux_addr(o_dram_mux_addr),
      .i_we_n(o_dram_write_en_n), .i_row1_n(o_row_strobe_bank1_n),
      .i_row2_n(o_row_strobe_bank2_n), .i_hi_n(o_col_strobe_hi_n),
      .i_lo_n(o_col_strobe_lo_n), .o_row(m_row), .o_col(m_col),
      .o_bank2(m_bank2), .o_we_n(m_we_n), .o_lanes(m_lanes),
      .o_col_cnt(m_cnt));

   // 10 MHz clock
   always #50 i_clk_sys = ~i_clk_sys;

   // Hang guard, well above the ten accesses of the run
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         bad_count++;
         complete_run();
      end
   end

   task chk(input string what, input logic [23:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One processor cycle: address first, then strobe, release after ack
   task access(input [23:0] a, input rw, input [1:0] sz, output int acks);
      acks = 0;
      @(posedge i_clk_sys);
      i_addr <= a;
      i_read_write_n <= rw;
      i_xfer_size <= sz;
      @(posedge i_clk_sys);
      i_addr_strobe_n <= 1'b0;
      repeat (40) begin
         @(negedge i_clk_sys);
         if (o_data_size_ack_n[1] === 1'b0) begin
            acks++;
            chk("ack code", `ACK_PORT16, o_data_size_ack_n);
         end else if (acks > 0) break;
      end
      @(posedge i_clk_sys);
      i_addr_strobe_n <= 1'b1;
   endtask

   task complete_run();
      $display("bad_count %0d tests_run %0d", bad_count, tests_run);
      if (bad_count == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      int acks;
      int n0;
      repeat (2) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      @(negedge i_clk_sys);
      chk("idle outputs", 7'h7f, ctl);
      foreach (rows[i]) begin
         n0 = m_cnt;
         access(rows[i].a, rows[i].rw, rows[i].sz, acks);
         chk("ack cycles", rows[i].acks, acks);
         chk("col strobes", n0 + 1, m_cnt);
         chk("lanes", rows[i].lanes, m_lanes);
         chk("row addr", rows[i].a[20:11], m_row);
         chk("col addr", rows[i].a[10:1], m_col);
         chk("bank", rows[i].a[21], m_bank2);
         chk("write", rows[i].rw, m_we_n);
      end
      // Address outside the DRAM region gets no answer
      n0 = m_cnt;
      access(24'h40_0000, 1'b1, `SIZE_WORD, acks);
      chk("refused acks", 0, acks);
      chk("refused strobes", n0, m_cnt);
      // Reset with a page open closes it; same page is then a miss
      @(posedge i_clk_sys);
      i_resetn <= 1'b0;
      @(negedge i_clk_sys);
      chk("reset outputs", 7'h7f, ctl);
      @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      access(24'h00_0802, 1'b1, `SIZE_WORD, acks);
      chk("after reset acks", 2, acks);
      complete_run();
   end
endmodule
